// [usb_buffer_descriptor_engine.sv]
// Behaviour
// - status bit 7 clear means core owns descriptor, set means engine owns.
// - expected toggle ignored unless toggle check enable is set.
// - toggle check drops mismatching data packets, SETUP always accepted.
// - stall bit answers token with STALL, descriptor left unchanged.
// - byte count is ten bits, high two in status bits 1:0.
// - engine overwrites software status settings with its result.
// - engine writes received token pid into status bits 5 to 2.
// - engine never writes status bit 6 in its layout.
// - written count low part to count byte, overflow to status bits.
// - IN sends count bytes and writes back bytes sent.
// - OUT count is maximum; writes back bytes received.
// - OUT packet longer than count gets NAK, count unchanged.
// - buffer address used as is, no range check.
// - mode 00 none, 01 ep0 out, 10 all, 11 all but ep0.
// - per endpoint direction pointer, even at enable, toggles per completed transaction on a double-buffered endpoint direction.
// - transfer status holds whether last completed transaction used odd descriptor.
// - pointer reset control returns all pointers to even.
// - descriptor index fixed by endpoint, direction, slot and mode.
// - engine clears ownership when a transaction completes.
// - toggle mismatch still gets ACK, no store, ownership kept.
// - SETUP on stalled descriptor clears stall, returns to core.
// - even and odd descriptors sit at consecutive indices, even first.
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "usb_bd_map.svh"
module usb_buffer_descriptor_engine
(
	input wire logic CLK_SYS,
	input wire logic RST_B,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic TOKEN_VALID,
	input wire usb_bd_pkg::token_type TOKEN,
	output logic TOKEN_READY,
	output logic ANSWER_VALID,
	output usb_bd_pkg::answer_type ANSWER,
	output logic DONE,
	output logic STALL_SENT
);
	import usb_bd_pkg::*;

	// ==========================================
	// storage and state
	logic [7:0] bd_mem [0:255];
	logic [3:0] cfg_q;
	logic [5:0] xstat_q;
	logic [31:0] ptr_q;
	state_type state_q;
	token_type tok_q;
	logic [1:0] mode;
	logic dir_in;
	logic slot;
	logic dbl;
	logic [5:0] idx;
	logic [7:0] stat;
	logic [9:0] cnt;
	logic [15:0] adr;
	logic is_setup;
	logic tog_bad;
	logic eng_wr;
	logic complete;
	hs_type hs_d;
	logic [9:0] cnt_d;
	logic apb_acc;
	logic apb_bd;
	logic apb_map;
	logic [31:0] rd_d;

	assign mode = cfg_q[`CFG_MODE_LO+1:`CFG_MODE_LO];
	assign dir_in = (tok_q.pid == `PID_IN);
	assign is_setup = (tok_q.pid == `PID_SETUP);

	// ==========================================
	// descriptor index selection
	// double buffering per mode
	always_comb
	begin
		case (mode)
			`MODE_NONE: dbl = 1'b0;
			`MODE_EP0OUT: dbl = (tok_q.ep == 4'h0) && !dir_in;
			`MODE_ALL: dbl = 1'b1;
			`MODE_NOT0: dbl = (tok_q.ep != 4'h0);
			default: dbl = 1'b0;
		endcase
	end

	assign slot = dbl & ptr_q[{tok_q.ep, dir_in}];

	// fixed index per endpoint, direction, slot
	always_comb
	begin
		case (mode)
			`MODE_NONE: idx = {1'b0, tok_q.ep, dir_in};
			`MODE_EP0OUT:
				idx = (tok_q.ep == 4'h0 && !dir_in) ? {5'h0, slot} :
					6'({1'b0, tok_q.ep, dir_in} + 6'h1);
			`MODE_ALL: idx = {tok_q.ep, dir_in, slot};
			`MODE_NOT0:
				idx = (tok_q.ep == 4'h0) ? {5'h0, dir_in} :
					6'({4'(tok_q.ep - 4'h1), dir_in, slot} + 6'h2);
			default: idx = 6'h0;
		endcase
	end

	// descriptor fields, address taken unchecked
	assign stat = bd_mem[{idx, 2'h0}];
	assign cnt = {stat[1:0], bd_mem[{idx, 2'h1}]};
	assign adr = {bd_mem[{idx, 2'h3}], bd_mem[{idx, 2'h2}]};

	// toggle compared only with check enabled
	assign tog_bad = stat[`TCHK_BIT] && !is_setup &&
		(tok_q.data_odd != stat[`TOG_BIT]);

	// ==========================================
	// transaction decision
	always_comb
	begin
		hs_d = HS_NAK;
		eng_wr = 1'b0;
		complete = 1'b0;
		cnt_d = cnt;
		if (!stat[`OWN_BIT])
			hs_d = HS_NAK;
		else if (stat[`STALL_BIT] && !is_setup)
			hs_d = HS_STALL;
		else if (tok_q.bad_packet)
			hs_d = HS_NAK;
		else if (dir_in)
		begin
			hs_d = HS_DATA;
			eng_wr = 1'b1;
			complete = 1'b1;
		end
		else if (tok_q.length > cnt)
			hs_d = HS_NAK;
		else if (tog_bad)
			hs_d = HS_ACK;
		else
		begin
			hs_d = HS_ACK;
			cnt_d = tok_q.length;
			eng_wr = 1'b1;
			complete = 1'b1;
		end
	end

	// ==========================================
	// apb decode
	assign apb_acc = PSEL && PENABLE && PREADY;
	assign apb_bd = (PADDR[11:10] == 2'h0);
	assign apb_map = apb_bd || PADDR == `CFG_ADDR ||
		PADDR == `XSTAT_ADDR || PADDR == `PTR_ADDR;

	// read mux
	always_comb
	begin
		rd_d = 32'h0;
		if (apb_bd)
			rd_d = {24'h0, bd_mem[PADDR[9:2]]};
		else if (PADDR == `CFG_ADDR)
			rd_d = {28'h0, cfg_q};
		else if (PADDR == `XSTAT_ADDR)
			rd_d = {26'h0, xstat_q};
		else if (PADDR == `PTR_ADDR)
			rd_d = ptr_q;
	end

	// one wait state per access
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			PREADY <= 1'b0;
			PRDATA <= 32'h0;
			PSLVERR <= 1'b0;
		end
		else
		begin
			PREADY <= PSEL && PENABLE && !PREADY;
			PRDATA <= rd_d;
			PSLVERR <= PSEL && PENABLE && !PREADY && !apb_map;
		end
	end

	// configuration register
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			cfg_q <= `CFG_RESET;
		else if (apb_acc && PWRITE && PADDR == `CFG_ADDR)
			cfg_q <= PWDATA[3:0];
	end

	// ==========================================
	// descriptor memory, engine write wins
	always_ff @(posedge CLK_SYS)
	begin
		if (state_q == ST_EVAL && eng_wr)
		begin
			bd_mem[{idx, 2'h0}] <= {1'b0, stat[`TOG_BIT], tok_q.pid,
				cnt_d[9:8]};
			bd_mem[{idx, 2'h1}] <= cnt_d[7:0];
		end
		else if (apb_acc && PWRITE && apb_bd)
			bd_mem[PADDR[9:2]] <= PWDATA[7:0];
	end

	// ==========================================
	// token sequencing
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			state_q <= ST_IDLE;
			tok_q <= '0;
		end
		else
		begin
			case (state_q)
				ST_IDLE:
					if (TOKEN_VALID && cfg_q[`CFG_EN_BIT])
					begin
						state_q <= ST_EVAL;
						tok_q <= TOKEN;
					end
				ST_EVAL: state_q <= ST_IDLE;
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// answer outputs
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
		begin
			ANSWER_VALID <= 1'b0;
			ANSWER <= '0;
			DONE <= 1'b0;
			STALL_SENT <= 1'b0;
			TOKEN_READY <= 1'b0;
		end
		else
		begin
			ANSWER_VALID <= (state_q == ST_EVAL);
			DONE <= (state_q == ST_EVAL) && complete;
			STALL_SENT <= (state_q == ST_EVAL) && hs_d == HS_STALL;
			TOKEN_READY <= cfg_q[`CFG_EN_BIT] &&
				!(state_q == ST_IDLE && TOKEN_VALID);
			if (state_q == ST_EVAL)
				ANSWER <= '{hs: hs_d, count: cnt_d, buf_addr: adr, odd: slot};
		end
	end

	// ==========================================
	// ping-pong pointers, one per endpoint direction
	genvar g;
	generate
		for (g = 0; g < 32; g = g + 1)
		begin : pp
			always_ff @(posedge CLK_SYS or negedge RST_B)
			begin
				if (!RST_B)
					ptr_q[g] <= 1'b0;
				else if (!cfg_q[`CFG_EN_BIT] || cfg_q[`CFG_PPRST_BIT])
					ptr_q[g] <= 1'b0;
				else if (state_q == ST_EVAL && complete && dbl &&
					{tok_q.ep, dir_in} == 5'(g))
					ptr_q[g] <= ~ptr_q[g];
			end
		end
	endgenerate

	// transfer status: endpoint, direction, odd slot
	always_ff @(posedge CLK_SYS or negedge RST_B)
	begin
		if (!RST_B)
			xstat_q <= 6'h0;
		else if (state_q == ST_EVAL && complete)
			xstat_q <= {tok_q.ep, dir_in, slot};
	end

	// ==========================================
	// checks
	ready_ack_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(PSEL && PENABLE && !PREADY) |=> PREADY)
		else $error("apb access not answered");
	stall_keep_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(state_q == ST_EVAL && hs_d == HS_STALL) |-> !eng_wr ##1 STALL_SENT)
		else $error("stall changed descriptor");
	own_clear_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(state_q == ST_EVAL && eng_wr && !(apb_acc && PWRITE)) |=>
		!bd_mem[{$past(idx), 2'h0}][`OWN_BIT])
		else $error("ownership not returned");
	tog_ack_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(state_q == ST_EVAL && stat[`OWN_BIT] && !stat[`STALL_BIT] &&
		!dir_in && !tok_q.bad_packet && tok_q.length <= cnt && tog_bad)
		|=> ANSWER.hs == HS_ACK && !DONE)
		else $error("toggle mismatch handled wrong");
	over_nak_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(state_q == ST_EVAL && stat[`OWN_BIT] && !stat[`STALL_BIT] &&
		!dir_in && !tok_q.bad_packet && tok_q.length > cnt)
		|=> ANSWER.hs == HS_NAK && !DONE)
		else $error("oversize packet not refused");
	setup_ok_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(state_q == ST_EVAL && is_setup && stat[`OWN_BIT] &&
		!tok_q.bad_packet && tok_q.length <= cnt) |=> DONE)
		else $error("setup not accepted");
	ptr_rst_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		cfg_q[`CFG_PPRST_BIT] |=> ptr_q == 32'h0)
		else $error("pointers not even after reset control");
	ptr_flip_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(state_q == ST_EVAL && complete && dbl && cfg_q[`CFG_EN_BIT] &&
		!cfg_q[`CFG_PPRST_BIT]) |=>
		ptr_q[{tok_q.ep, dir_in}] != $past(slot))
		else $error("pointer did not toggle");
	odd_flag_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		DONE |-> xstat_q[0] == ANSWER.odd)
		else $error("odd flag mismatch");
	cnt_back_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(DONE && ANSWER.hs == HS_ACK) |-> ANSWER.count == $past(tok_q.length))
		else $error("count not written back");
	// write-back layout of the status and count bytes
	pid_store_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(state_q == ST_EVAL && eng_wr) |=>
		bd_mem[{$past(idx), 2'h0}][`PID_HI:`PID_LO] == $past(tok_q.pid))
		else $error("token pid not stored");
	tog_keep_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(state_q == ST_EVAL && eng_wr) |=>
		bd_mem[{$past(idx), 2'h0}][`TOG_BIT] == $past(stat[`TOG_BIT]))
		else $error("reserved status bit written");
	cnt_split_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(state_q == ST_EVAL && eng_wr) |=>
		{bd_mem[{$past(idx), 2'h0}][1:0], bd_mem[{$past(idx), 2'h1}]} ==
		$past(cnt_d))
		else $error("count bytes split wrong");

	// stalled descriptor left exactly as software wrote it
	stall_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(state_q == ST_EVAL && hs_d == HS_STALL && !(apb_acc && PWRITE)) |=>
		bd_mem[{$past(idx), 2'h0}] == $past(stat))
		else $error("stalled descriptor changed");

	// in answers carry the armed count unchanged
	in_count_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		(state_q == ST_EVAL && hs_d == HS_DATA) |=>
		ANSWER.count == $past(cnt) && DONE)
		else $error("in count not reported");

	// pointers parked on even while the module is off
	dis_even_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		!cfg_q[`CFG_EN_BIT] |=> ptr_q == 32'h0)
		else $error("pointers not even while disabled");

	// bus error comes only with ready, answer pulses last one cycle
	err_ready_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		PSLVERR |-> PREADY)
		else $error("error without ready");
	answer_pulse_a: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
		ANSWER_VALID |=> !ANSWER_VALID)
		else $error("answer pulse too long");

	nak_cover: cover property (@(posedge CLK_SYS)
		ANSWER_VALID && ANSWER.hs == HS_NAK);
	in_cover: cover property (@(posedge CLK_SYS) DONE && ANSWER.hs == HS_DATA);
	out_cover: cover property (@(posedge CLK_SYS) DONE && ANSWER.hs == HS_ACK);
	stall_cover: cover property (@(posedge CLK_SYS) STALL_SENT);
	odd_cover: cover property (@(posedge CLK_SYS) DONE && ANSWER.odd);
endmodule // usb_buffer_descriptor_engine
`default_nettype wire

// [usb_bd_map.svh]
`ifndef USB_BD_MAP_SVH
`define USB_BD_MAP_SVH
// ==========================================
// status byte fields
`define OWN_BIT 7
`define TOG_BIT 6
`define PID_HI 5
`define PID_LO 2
`define TCHK_BIT 3
`define STALL_BIT 2
// ==========================================
// token pids
`define PID_OUT 4'h1
`define PID_IN 4'h9
`define PID_SETUP 4'hd
// ==========================================
// apb map
`define CFG_ADDR 12'h400
`define XSTAT_ADDR 12'h404
`define PTR_ADDR 12'h408
`define CFG_EN_BIT 0
`define CFG_PPRST_BIT 1
`define CFG_MODE_LO 2
`define CFG_RESET 4'h0
`define MODE_NONE 2'h0
`define MODE_EP0OUT 2'h1
`define MODE_ALL 2'h2
`define MODE_NOT0 2'h3
`endif

// [usb_bd_pkg.sv]
package usb_bd_pkg;
	typedef struct packed {
		logic [3:0] pid;
		logic [3:0] ep;
		logic data_odd;
		logic [9:0] length;
		logic bad_packet;
	} token_type;
	typedef enum logic [1:0] {
		HS_ACK = 2'h0,
		HS_NAK = 2'h1,
		HS_STALL = 2'h2,
		HS_DATA = 2'h3
	} hs_type;
	typedef struct packed {
		hs_type hs;
		logic [9:0] count;
		logic [15:0] buf_addr;
		logic odd;
	} answer_type;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_EVAL = 2'h2
	} state_type;
endpackage

// [usb_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// host stand-in: offers one token per request
module usb_host_model
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic go,
	input wire usb_bd_pkg::token_type tok,
	input wire logic token_ready,
	output logic token_valid,
	output usb_bd_pkg::token_type token
);
	import usb_bd_pkg::*;
	token_type held_q;
	logic valid_q;
	// hold the token until the engine takes it
	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			valid_q <= 1'b0;
			held_q <= '0;
		end
		else if (valid_q && token_ready)
			valid_q <= 1'b0;
		else if (go && !valid_q)
		begin
			valid_q <= 1'b1;
			held_q <= tok;
		end
	end
	// idle bus shows the inverse, never a stale token
	assign token = valid_q ? held_q : ~held_q;
	assign token_valid = valid_q;
endmodule // usb_host_model
`default_nettype wire

// [tb_usb_buffer_descriptor_engine.sv]
`timescale 1ns/1ns
`default_nettype none
`include "usb_bd_map.svh"
module tb_usb_buffer_descriptor_engine;
	import usb_bd_pkg::*;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic go = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready, pslverr, tv, tr, av, dn, ss, err, g_dn, g_ss;
	token_type tkn;
	token_type tok = '0;
	answer_type answer;
	answer_type ans;
	int mismatches = 0;
	int total_checks = 0;
	int ep1_in[4] = '{3, 4, 6, 4};
	always #20 clk = ~clk;
	usb_buffer_descriptor_engine dut_u (.CLK_SYS(clk), .RST_B(rst_b),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .TOKEN_VALID(tv), .TOKEN(tkn),
		.TOKEN_READY(tr), .ANSWER_VALID(av), .ANSWER(answer),
		.DONE(dn), .STALL_SENT(ss));
	usb_host_model host_u (.clk(clk), .rst_b(rst_b), .go(go), .tok(tok),
		.token_ready(tr), .token_valid(tv), .token(tkn));
	// ==========================================
	// verdict and compare
	task automatic final_report();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// ==========================================
	// apb transfer, waits for pready under a bound
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		if (pready !== 1'b1)
		begin
			mismatches++;
			$display("mismatch at %0t: bus timeout", $time);
			final_report();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
		input logic e_err);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
		chk(32'(err), 32'(e_err));
	endtask
	// descriptor fields first, status byte last
	task automatic desc(input int i, input logic [7:0] st,
		input logic [7:0] c, input logic [15:0] ad);
		apb(1'b1, 12'(i * 16 + 4), {24'h0, c});
		apb(1'b1, 12'(i * 16 + 8), {24'h0, ad[7:0]});
		apb(1'b1, 12'(i * 16 + 12), {24'h0, ad[15:8]});
		apb(1'b1, 12'(i * 16), {24'h0, st});
	endtask
	// one token through the host model, answer captured
	task automatic tx(input logic [3:0] p, input logic [3:0] e,
		input logic o, input logic [9:0] l, input logic bp);
		int n;
		tok <= '{p, e, o, l, bp};
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (av !== 1'b1 && n < 20);
		ans = answer;
		g_dn = dn;
		g_ss = ss;
		if (av !== 1'b1)
		begin
			mismatches++;
			$display("mismatch at %0t: answer timeout", $time);
			final_report();
		end
		@(posedge clk);
	endtask
	task automatic ack(input hs_type h, input logic d, input logic s);
		chk(32'({ans.hs, g_dn, g_ss}), 32'({h, d, s}));
	endtask
	// ==========================================
	// main sequence
	initial
	begin
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		rdchk(`CFG_ADDR, 32'h0, 1'b0);
		chk(32'(tr), 32'h0);
		rdchk(12'h40c, 32'h0, 1'b1);
		apb(1'b1, `CFG_ADDR, 32'h1);
		desc(0, 8'h88, 8'h08, 16'h0500);
		chk(32'(tr), 32'h1);
		tx(`PID_OUT, 4'h0, 1'b1, 10'd5, 1'b0);
		ack(HS_ACK, 1'b0, 1'b0);
		rdchk(12'h000, 32'h88, 1'b0);
		tx(`PID_OUT, 4'h0, 1'b0, 10'd5, 1'b1);
		ack(HS_NAK, 1'b0, 1'b0);
		tx(`PID_OUT, 4'h0, 1'b0, 10'd5, 1'b0);
		ack(HS_ACK, 1'b1, 1'b0);
		chk(32'(ans.count), 32'd5);
		rdchk(12'h000, 32'h04, 1'b0);
		rdchk(12'h004, 32'h05, 1'b0);
		tx(`PID_OUT, 4'h0, 1'b0, 10'd1, 1'b0);
		ack(HS_NAK, 1'b0, 1'b0);
		desc(0, 8'hc0, 8'h03, 16'h0500);
		tx(`PID_OUT, 4'h0, 1'b0, 10'd4, 1'b0);
		ack(HS_NAK, 1'b0, 1'b0);
		rdchk(12'h004, 32'h03, 1'b0);
		tx(`PID_OUT, 4'h0, 1'b0, 10'd3, 1'b0);
		ack(HS_ACK, 1'b1, 1'b0);
		rdchk(12'h000, 32'h44, 1'b0);
		desc(1, 8'h84, 8'h00, 16'h0000);
		tx(`PID_IN, 4'h0, 1'b0, 10'd0, 1'b0);
		ack(HS_STALL, 1'b0, 1'b1);
		rdchk(12'h010, 32'h84, 1'b0);
		desc(0, 8'h8c, 8'h08, 16'h0500);
		tx(`PID_SETUP, 4'h0, 1'b1, 10'd8, 1'b0);
		ack(HS_ACK, 1'b1, 1'b0);
		rdchk(12'h000, 32'h34, 1'b0);
		desc(1, 8'hc1, 8'h2c, 16'h1234);
		tx(`PID_IN, 4'h0, 1'b0, 10'd0, 1'b0);
		ack(HS_DATA, 1'b1, 1'b0);
		chk(32'({ans.count, ans.buf_addr}), 32'({10'd300, 16'h1234}));
		rdchk(12'h010, 32'h65, 1'b0);
		apb(1'b1, `CFG_ADDR, 32'h9);
		desc(4, 8'h80, 8'h08, 16'h0040);
		desc(5, 8'h80, 8'h08, 16'h0050);
		tx(`PID_OUT, 4'h1, 1'b0, 10'd2, 1'b0);
		chk(32'({ans.odd, ans.buf_addr}), 32'h0040);
		rdchk(`XSTAT_ADDR, 32'h04, 1'b0);
		rdchk(`PTR_ADDR, 32'h04, 1'b0);
		tx(`PID_OUT, 4'h1, 1'b1, 10'd2, 1'b0);
		chk(32'({ans.odd, ans.buf_addr}), 32'h10050);
		rdchk(`XSTAT_ADDR, 32'h05, 1'b0);
		desc(4, 8'h80, 8'h08, 16'h0040);
		tx(`PID_OUT, 4'h1, 1'b0, 10'd2, 1'b0);
		apb(1'b1, `CFG_ADDR, 32'hb);
		apb(1'b1, `CFG_ADDR, 32'h9);
		rdchk(`PTR_ADDR, 32'h0, 1'b0);
		for (int m = 0; m < 4; m++)
		begin
			apb(1'b1, `CFG_ADDR, 32'(3 + m * 4));
			apb(1'b1, `CFG_ADDR, 32'(1 + m * 4));
			desc(ep1_in[m], 8'h80, 8'(m + 1), 16'(ep1_in[m]));
			tx(`PID_IN, 4'h1, 1'b0, 10'd0, 1'b0);
			chk(32'({ans.count, ans.buf_addr}),
				32'({10'(m + 1), 16'(ep1_in[m])}));
		end
		final_report();
	end
endmodule // tb_usb_buffer_descriptor_engine
`default_nettype wire
